/* hw/scrb_map.svh */
// register map constants of the shadowed channel register bank
// assumes a byte-wide register port with the serial framing decoded outside
// Operation
// - addresses and bits not in the map do nothing; they read as zero
// - any reset loads documented defaults into all control registers
// - 0x08-0x18 and 0x11e-0x123 writes only touch holding copies
// - writing 0x01 to 0xff copies all holding copies at once, bit self-clears
// - local registers exist per channel, steered by channel bits of 0x05
// - both channel bits set: a local write updates both channels
// - reads should select one channel; both set returns channel a copy
// - global registers ignore the channel selection completely
// - port config is nibble mirrored: lsb first, soft reset, fixed ones
// - clock divide field divides by value plus one; nonzero forces stabilizer
`ifndef SCRB_MAP_SVH
`define SCRB_MAP_SVH

// byte addresses
`define SCRB_ADDR_PORT_CFG 13'h000
`define SCRB_ADDR_PART_ID 13'h001
`define SCRB_ADDR_SPEED 13'h002
`define SCRB_ADDR_CH_SEL 13'h005
`define SCRB_ADDR_POWER 13'h008
`define SCRB_ADDR_GCLK 13'h009
`define SCRB_ADDR_CLKDIV 13'h00b
`define SCRB_ADDR_XFER 13'h0ff

// reset values
`define SCRB_RST_PORT_CFG 8'h18
`define SCRB_RST_CH_SEL 2'h3
`define SCRB_RST_PM 2'h0
`define SCRB_RST_PD_PIN 1'h0
`define SCRB_RST_DCS 1'h1
`define SCRB_RST_DIV 3'h0

// port config field positions (mirrored pairs)
`define SCRB_CFG_LSB_HI 6
`define SCRB_CFG_LSB_LO 1
`define SCRB_CFG_SRST_HI 5
`define SCRB_CFG_SRST_LO 2
`define SCRB_CFG_FIXED 8'h18

// other field positions
`define SCRB_CH_A 0
`define SCRB_CH_B 1
`define SCRB_PM_LSB 0
`define SCRB_PD_PIN_BIT 5
`define SCRB_DCS_BIT 0
`define SCRB_DIV_LSB 0
`define SCRB_XFER_BIT 0

`endif

/* hw/scrb_pkg.sv */
// types of the shadowed channel register bank
// assumes scrb_map.svh sits on the include path
`include "scrb_map.svh"

package scrb_pkg;

	// whole module state, registered as one word
	typedef struct packed {
		logic lsb_first;
		logic [1:0] ch_sel;
		logic [1:0] hold_pm_a;
		logic [1:0] hold_pm_b;
		logic hold_pd_pin;
		logic hold_dcs;
		logic [2:0] hold_div;
		logic [1:0] act_pm_a;
		logic [1:0] act_pm_b;
		logic act_pd_pin;
		logic act_dcs;
		logic [2:0] act_div;
		logic [2:0] div_cnt;
		logic clk_en;
		logic [7:0] rdata;
		logic rvalid;
	} scrb_state_type;

	// defaults loaded by power-on and soft reset
	function automatic scrb_state_type scrb_reset_state();
		scrb_state_type s;
		logic [7:0] cfg;
		s = '0;
		cfg = `SCRB_RST_PORT_CFG;
		s.lsb_first = cfg[`SCRB_CFG_LSB_LO]; // one bit taken on purpose
		s.ch_sel = `SCRB_RST_CH_SEL;
		s.hold_pm_a = `SCRB_RST_PM;
		s.hold_pm_b = `SCRB_RST_PM;
		s.hold_pd_pin = `SCRB_RST_PD_PIN;
		s.hold_dcs = `SCRB_RST_DCS;
		s.hold_div = `SCRB_RST_DIV;
		s.act_pm_a = `SCRB_RST_PM;
		s.act_pm_b = `SCRB_RST_PM;
		s.act_pd_pin = `SCRB_RST_PD_PIN;
		s.act_dcs = `SCRB_RST_DCS;
		s.act_div = `SCRB_RST_DIV;
		return s;
	endfunction : scrb_reset_state

endpackage : scrb_pkg

/* hw/scrb_top.sv */
// shadowed channel register bank of a dual-channel receiver
// assumes the serial port framing is decoded outside into one-cycle byte accesses
`timescale 1ns/1ps
`include "scrb_map.svh"

module scrb_top #(
	parameter int ADDR_W = 13,
	parameter logic [7:0] PART_ID = 8'h5a, // arbitrary identity value
	parameter logic [7:0] SPEED_ID = 8'h00
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// decoded serial port accesses
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	// applied controls
	output logic lsb_first_o,
	output logic [1:0] power_mode_a_o,
	output logic [1:0] power_mode_b_o,
	output logic pd_pin_standby_o,
	output logic duty_cycle_stabilizer_o,
	output logic [2:0] clk_div_o,
	output logic conv_clk_en_o
);
	import scrb_pkg::*;

	// the map needs nine address bits for 0x123; refused at elaboration
	if (ADDR_W < 9) begin : g_bad_addr_w
		$error("scrb_top: ADDR_W must be at least 9");
	end

	scrb_state_type st_q;
	scrb_state_type st_d;

	// address match, widened to the port width
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [12:0] r);
		return a == ADDR_W'(r);
	endfunction : hit

	// port config reads mirrored; soft reset bits read zero as they self-clear
	function automatic logic [7:0] cfg_image(input logic lsb);
		logic [7:0] v;
		v = `SCRB_CFG_FIXED;
		v[`SCRB_CFG_LSB_HI] = lsb;
		v[`SCRB_CFG_LSB_LO] = lsb;
		return v;
	endfunction : cfg_image

	// power modes byte, local field taken from the chosen channel
	function automatic logic [7:0] pm_image(input logic [1:0] pm, input logic pd);
		logic [7:0] v;
		v = 8'h00;
		v[`SCRB_PM_LSB +: 2] = pm;
		v[`SCRB_PD_PIN_BIT] = pd;
		return v;
	endfunction : pm_image

	logic [1:0] rd_pm;
	logic soft_rst;

	// channel b only when b alone is chosen; both set gives channel a
	assign rd_pm = (st_q.ch_sel == 2'h2) ? st_q.hold_pm_b : st_q.hold_pm_a;

	// either mirrored soft reset bit triggers a return to defaults
	assign soft_rst = wr_en_i && hit(addr_i, `SCRB_ADDR_PORT_CFG) &&
		(wdata_i[`SCRB_CFG_SRST_HI] || wdata_i[`SCRB_CFG_SRST_LO]);

	// next-state logic
	always_comb begin
		st_d = st_q;
		st_d.rvalid = 1'b0;
		// divider: one enable pulse every (field + 1) clocks
		if (st_q.div_cnt >= st_q.act_div) begin
			st_d.div_cnt = 3'h0;
			st_d.clk_en = 1'b1;
		end else begin
			st_d.div_cnt = st_q.div_cnt + 3'h1;
			st_d.clk_en = 1'b0;
		end
		// register writes; unmapped addresses fall through untouched
		if (soft_rst) begin
			st_d = scrb_reset_state();
		end else if (wr_en_i) begin
			if (hit(addr_i, `SCRB_ADDR_PORT_CFG)) begin
				// either mirror copy sets the order, so both shift orders agree
				st_d.lsb_first = wdata_i[`SCRB_CFG_LSB_HI] | wdata_i[`SCRB_CFG_LSB_LO];
			end else if (hit(addr_i, `SCRB_ADDR_CH_SEL)) begin
				st_d.ch_sel = wdata_i[`SCRB_CH_A +: 2];
			end else if (hit(addr_i, `SCRB_ADDR_POWER)) begin
				// local field only reaches the selected channel copies
				if (st_q.ch_sel[`SCRB_CH_A]) begin
					st_d.hold_pm_a = wdata_i[`SCRB_PM_LSB +: 2];
				end
				if (st_q.ch_sel[`SCRB_CH_B]) begin
					st_d.hold_pm_b = wdata_i[`SCRB_PM_LSB +: 2];
				end
				st_d.hold_pd_pin = wdata_i[`SCRB_PD_PIN_BIT];
			end else if (hit(addr_i, `SCRB_ADDR_GCLK)) begin
				st_d.hold_dcs = wdata_i[`SCRB_DCS_BIT];
			end else if (hit(addr_i, `SCRB_ADDR_CLKDIV)) begin
				st_d.hold_div = wdata_i[`SCRB_DIV_LSB +: 3];
			end else if (hit(addr_i, `SCRB_ADDR_XFER)) begin
				// all shadowed copies move together; the bit is never stored
				if (wdata_i[`SCRB_XFER_BIT]) begin
					st_d.act_pm_a = st_q.hold_pm_a;
					st_d.act_pm_b = st_q.hold_pm_b;
					st_d.act_pd_pin = st_q.hold_pd_pin;
					st_d.act_dcs = st_q.hold_dcs;
					st_d.act_div = st_q.hold_div;
				end
			end
		end
		// reads answer one clock later; unsupported locations read zero
		if (rd_en_i) begin
			st_d.rvalid = 1'b1;
			if (hit(addr_i, `SCRB_ADDR_PORT_CFG)) begin
				st_d.rdata = cfg_image(st_q.lsb_first);
			end else if (hit(addr_i, `SCRB_ADDR_PART_ID)) begin
				st_d.rdata = PART_ID;
			end else if (hit(addr_i, `SCRB_ADDR_SPEED)) begin
				st_d.rdata = SPEED_ID;
			end else if (hit(addr_i, `SCRB_ADDR_CH_SEL)) begin
				st_d.rdata = {6'h00, st_q.ch_sel};
			end else if (hit(addr_i, `SCRB_ADDR_POWER)) begin
				st_d.rdata = pm_image(rd_pm, st_q.hold_pd_pin);
			end else if (hit(addr_i, `SCRB_ADDR_GCLK)) begin
				st_d.rdata = {7'h00, st_q.hold_dcs};
			end else if (hit(addr_i, `SCRB_ADDR_CLKDIV)) begin
				st_d.rdata = {5'h00, st_q.hold_div};
			end else begin
				st_d.rdata = 8'h00;
			end
		end
	end

	// state register
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= scrb_reset_state();
		end else begin
			st_q <= st_d;
		end
	end

	// outputs straight from flip-flops, except the divider-forced stabilizer
	assign rdata_o = st_q.rdata;
	assign rvalid_o = st_q.rvalid;
	assign lsb_first_o = st_q.lsb_first;
	assign power_mode_a_o = st_q.act_pm_a;
	assign power_mode_b_o = st_q.act_pm_b;
	assign pd_pin_standby_o = st_q.act_pd_pin;
	assign duty_cycle_stabilizer_o = st_q.act_dcs | (st_q.act_div != 3'h0);
	assign clk_div_o = st_q.act_div;
	assign conv_clk_en_o = st_q.clk_en;

endmodule : scrb_top

/* verification/scrb_properties.sv */
// checker for the shadowed channel register bank
// assumes binding onto scrb_top; one clock domain
`timescale 1ns/1ps
module scrb_properties #(
	parameter int ADDR_W = 13
) (
	// watched ports
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] rdata_o,
	input wire logic rvalid_o,
	input wire logic lsb_first_o,
	input wire logic [1:0] power_mode_a_o,
	input wire logic [2:0] clk_div_o,
	input wire logic duty_cycle_stabilizer_o,
	input wire logic conv_clk_en_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	// a write in the read cycle may soft reset, so plain reads only
	wire rd_only = rd_en_i && !wr_en_i;
	AST_OPEN_RD: assert property (rd_only && addr_i == 13'h003 |=> rvalid_o && rdata_o == 8'h00)
		else $error("open read");
	AST_CHSEL_PAD: assert property (rd_only && addr_i == 13'h005 |=> rdata_o[7:2] == 6'h00)
		else $error("chsel pad");
	AST_RST_DEF: assert property ($rose(rst_b_i) |-> !rvalid_o && !lsb_first_o
		&& clk_div_o == 3'h0 && duty_cycle_stabilizer_o && power_mode_a_o == 2'h0)
		else $error("reset default");
	AST_SHADOW: assert property (wr_en_i && addr_i == 13'h00b |=> $stable(clk_div_o))
		else $error("shadow leak");
	AST_XFER_CLR: assert property (rd_only && addr_i == 13'h0ff |=> rdata_o == 8'h00)
		else $error("xfer stuck");
	AST_DCS: assert property (clk_div_o != 3'h0 |-> duty_cycle_stabilizer_o)
		else $error("dcs off");
	AST_MIRROR: assert property (rd_only && addr_i == 13'h000 |=> rdata_o[4:3] == 2'h3
		&& rdata_o[6] == lsb_first_o && rdata_o[1] == lsb_first_o && !rdata_o[7] && !rdata_o[0])
		else $error("cfg mirror");
	AST_SOFT_RST: assert property (wr_en_i && addr_i == 13'h000 && wdata_i[5]
		|=> clk_div_o == 3'h0 && !conv_clk_en_o && !rvalid_o)
		else $error("soft reset");
endmodule : scrb_properties

bind scrb_top scrb_properties #(.ADDR_W(ADDR_W)) u_scrb_properties (
	.clk_sys_i(clk_sys_i),
	.rst_b_i(rst_b_i),
	.wr_en_i(wr_en_i),
	.rd_en_i(rd_en_i),
	.addr_i(addr_i),
	.wdata_i(wdata_i),
	.rdata_o(rdata_o),
	.rvalid_o(rvalid_o),
	.lsb_first_o(lsb_first_o),
	.power_mode_a_o(power_mode_a_o),
	.clk_div_o(clk_div_o),
	.duty_cycle_stabilizer_o(duty_cycle_stabilizer_o),
	.conv_clk_en_o(conv_clk_en_o)
);

/* verification/scrb_host.sv */
// host model issuing decoded byte accesses
// assumes strobes are taken on the rising edge
`timescale 1ns/1ps
module scrb_host (
	// clock
	input wire logic clk_sys_i,
	// access toward the block
	output logic wr_en_o = 1'b0,
	output logic rd_en_o = 1'b0,
	output logic [12:0] addr_o = 13'h000,
	output logic [7:0] wdata_o = 8'h00,
	// read answer
	input wire logic [7:0] rdata_i,
	input wire logic rvalid_i
);
	// callers keep unused bits zero and never write fully open places
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		wr_en_o <= 1'b1;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_sys_i);
		wr_en_o <= 1'b0;
		wdata_o <= ~d; // stale data must not count once the strobe drops
		#1;
	endtask : wr
	// data is taken beside the one-cycle valid pulse
	task automatic rd(input logic [12:0] a, output logic [7:0] d, output logic v);
		@(posedge clk_sys_i);
		rd_en_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_sys_i);
		rd_en_o <= 1'b0;
		#1;
		d = rdata_i;
		v = rvalid_i;
	endtask : rd
endmodule : scrb_host

/* verification/tb_top.sv */
// self-checking bench for the shadowed channel register bank
// assumes the host model makes every access
`timescale 1ns/1ps
module tb_top;
	logic clk_sys_i = 1'b0;
	logic rst_b_i;
	logic wr, rd, v, vld, lsb, pd, duty_cycle_stabilizer, cen;
	logic [12:0] adr;
	logic [7:0] wd, rdat, d;
	logic [1:0] pa, pb;
	logic [2:0] div;
	int err_total = 0;
	int samples_checked = 0;
	int n = 0;
	always #10 clk_sys_i = ~clk_sys_i;
	scrb_top #(.PART_ID(8'h3c)) u_scrb_top ( // arbitrary identity value
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .wr_en_i(wr), .rd_en_i(rd),
		.addr_i(adr), .wdata_i(wd), .rdata_o(rdat), .rvalid_o(vld),
		.lsb_first_o(lsb), .power_mode_a_o(pa), .power_mode_b_o(pb),
		.pd_pin_standby_o(pd), .duty_cycle_stabilizer_o(duty_cycle_stabilizer),
		.clk_div_o(div), .conv_clk_en_o(cen));
	scrb_host u_scrb_host (.clk_sys_i(clk_sys_i), .wr_en_o(wr), .rd_en_o(rd),
		.addr_o(adr), .wdata_o(wd), .rdata_i(rdat), .rvalid_i(vld));
	task automatic chk(string s, logic [7:0] seen, logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", s, exp, seen);
		end
	endtask : chk
	task automatic rchk(logic [12:0] a, logic [7:0] exp);
		u_scrb_host.rd(a, d, v);
		chk("rvalid", {7'h0, v}, 8'h01);
		chk("rdata", d, exp);
	endtask : rchk
	task automatic print_verdict();
		if (err_total == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict
	// a hang costs a mismatch; the whole run needs about 1.4 us
	initial begin
		#50000;
		err_total++;
		print_verdict();
	end
	// reset falls at time zero by a scheduled update so the async branch sees it
	initial begin
		rst_b_i <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		rchk(13'h000, 8'h18);
		rchk(13'h001, 8'h3c);
		rchk(13'h005, 8'h03);
		rchk(13'h009, 8'h01);
		rchk(13'h003, 8'h00);
		// divider only moves on transfer
		u_scrb_host.wr(13'h00b, 8'h03);
		chk("div", {5'h0, div}, 8'h00);
		rchk(13'h00b, 8'h03);
		u_scrb_host.wr(13'h0ff, 8'h01);
		chk("div", {5'h0, div}, 8'h03);
		rchk(13'h0ff, 8'h00);
		repeat (8) @(negedge clk_sys_i) n += int'(cen);
		chk("pulses", n[7:0], 8'h02);
		// both channels selected, then channel b alone, then channel a alone, then both again
		u_scrb_host.wr(13'h008, 8'h21);
		u_scrb_host.wr(13'h0ff, 8'h01);
		chk("pm", {4'h0, pb, pa}, 8'h05);
		u_scrb_host.wr(13'h005, 8'h02);
		u_scrb_host.wr(13'h008, 8'h22);
		u_scrb_host.wr(13'h009, 8'h00);
		rchk(13'h008, 8'h22);
		u_scrb_host.wr(13'h005, 8'h01);
		rchk(13'h008, 8'h21);
		rchk(13'h009, 8'h00);
		u_scrb_host.wr(13'h005, 8'h03);
		rchk(13'h008, 8'h21);
		u_scrb_host.wr(13'h0ff, 8'h01);
		chk("pm", {2'h0, pd, duty_cycle_stabilizer, pb, pa}, 8'h39);
		u_scrb_host.wr(13'h000, 8'h42);
		rchk(13'h000, 8'h5a);
		u_scrb_host.wr(13'h000, 8'h24);
		chk("soft", {pb, pa, div, lsb}, 8'h00);
		// a pin reset in mid-run must also bring the active divider back
		u_scrb_host.wr(13'h00b, 8'h02);
		u_scrb_host.wr(13'h0ff, 8'h01);
		chk("div", {5'h0, div}, 8'h02);
		@(posedge clk_sys_i);
		rst_b_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		@(negedge clk_sys_i);
		chk("rst div", {4'h0, duty_cycle_stabilizer, div}, 8'h08);
		rchk(13'h00b, 8'h00);
		print_verdict();
	end
endmodule : tb_top
